// file: design/ltg_timers.sv
`timescale 1ns/10ps
`default_nettype none
`include "ltg_cfg.svh"

module ltg_timers
  import ltg_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire ltg_pins_type src_pins,
  input  wire logic         low_power,
  input  wire logic [31:0]  irq_src,
  output logic              lt_irq,
  output logic              gt_irq
);

  function automatic logic pre_hit(input logic [14:0] cnt, input logic [3:0] code);
    logic [15:0] m;
    m = (16'h0001 << code) - 16'h0001;
    return (cnt & m[14:0]) == m[14:0];
  endfunction

  function automatic logic [31:0] tm_max(input logic [7:0] hr);
    return {hr, `LTG_MIN_MAX, `LTG_SEC_MAX, `LTG_HUND_MAX};
  endfunction

  // Hours, minutes, seconds, hundredths in one byte each
  function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up,
                                          input logic [7:0] hr_max);
    logic [7:0] h;
    logic [7:0] mi;
    logic [7:0] s;
    logic [7:0] c;
    {h, mi, s, c} = v;
    if (up) begin
      if (c < `LTG_HUND_MAX) c = c + 8'd1;
      else begin
        c = 8'd0;
        if (s < `LTG_SEC_MAX) s = s + 8'd1;
        else begin
          s = 8'd0;
          if (mi < `LTG_MIN_MAX) mi = mi + 8'd1;
          else begin
            mi = 8'd0;
            h = (h < hr_max) ? h + 8'd1 : 8'd0;
          end
        end
      end
    end else begin
      if (c != 8'd0) c = c - 8'd1;
      else begin
        c = `LTG_HUND_MAX;
        if (s != 8'd0) s = s - 8'd1;
        else begin
          s = `LTG_SEC_MAX;
          if (mi != 8'd0) mi = mi - 8'd1;
          else begin
            mi = `LTG_MIN_MAX;
            h = (h != 8'd0) ? h - 8'd1 : hr_max;
          end
        end
      end
    end
    return {h, mi, s, c};
  endfunction

  // Pin source synchronisers, edge counted once stages two and three agree
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [4:0] pin_lvl_q;
  logic [4:0] pin_rise;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1_q[gi]  <= 1'b0;
          pin_s2_q[gi]  <= 1'b0;
          pin_s3_q[gi]  <= 1'b0;
          pin_lvl_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= src_pins[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) pin_lvl_q[gi] <= pin_s3_q[gi];
        end
      end
      assign pin_rise[gi] = pin_s2_q[gi] & pin_s3_q[gi] & ~pin_lvl_q[gi];
    end
  endgenerate

  // Pin order in the struct: lp_osc, xtal, prec_osc, gpio8, gpio5
  logic rise_lp;
  logic rise_xtal;
  logic rise_prec;
  logic rise_g8;
  logic rise_g5;
  assign {rise_lp, rise_xtal, rise_prec, rise_g8, rise_g5} = pin_rise;

  // APB decode
  logic acc;
  logic setup;
  logic wr;
  logic hit;
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  always_comb begin
    case (paddr)
      `LTG_LT_LOAD_ADDR, `LTG_LT_VAL0_ADDR, `LTG_LT_VAL1_ADDR, `LTG_LT_CON_ADDR,
      `LTG_LT_CLR_ADDR, `LTG_LT_CAP_ADDR, `LTG_GT_LOAD_ADDR, `LTG_GT_VAL_ADDR,
      `LTG_GT_CON_ADDR, `LTG_GT_CLR_ADDR, `LTG_GT_CAP_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  logic wr_lt_load;
  logic wr_lt_con;
  logic wr_lt_clr;
  logic wr_gt_load;
  logic wr_gt_con;
  logic wr_gt_clr;
  assign wr_lt_load = wr && paddr == `LTG_LT_LOAD_ADDR;
  assign wr_lt_con = wr && paddr == `LTG_LT_CON_ADDR;
  assign wr_lt_clr = wr && paddr == `LTG_LT_CLR_ADDR;
  assign wr_gt_load = wr && paddr == `LTG_GT_LOAD_ADDR;
  assign wr_gt_con = wr && paddr == `LTG_GT_CON_ADDR;
  assign wr_gt_clr = wr && paddr == `LTG_GT_CLR_ADDR;

  // Capture source edge detect
  logic [31:0] irq_src_q;
  logic [31:0] src_rise;
  assign src_rise = irq_src & ~irq_src_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_src_q <= 32'h00000000;
    else irq_src_q <= irq_src;
  end

  // Lifetime timer
  ltg_lt_ctl_type lt_ctl_q;
  logic [15:0]    lt_load_q;
  logic [47:0]    lt_cnt_q;
  logic [15:0]    lt_cap_q;
  logic [14:0]    lt_pre_q;
  logic           lt_irq_q;
  logic           lt_src;
  logic           lt_tick;
  logic           lt_end;
  logic           lt_to;
  logic           lt_cap_hit;
  logic [15:0]    lt_start;

  always_comb begin
    case (lt_ctl_q.clk)
      2'd0:    lt_src = 1'b1;
      2'd1:    lt_src = rise_lp;
      2'd2:    lt_src = rise_xtal;
      default: lt_src = rise_prec;
    endcase
  end

  assign lt_tick = lt_ctl_q.en & lt_src & pre_hit(lt_pre_q, lt_ctl_q.pre);
  assign lt_end = lt_ctl_q.wide ? (lt_cnt_q == 48'hffffffffffff) :
                  lt_ctl_q.up ? (lt_cnt_q[15:0] == 16'hffff) : (lt_cnt_q[15:0] == 16'h0000);
  assign lt_to = lt_tick & lt_end;
  assign lt_start = lt_ctl_q.per ? lt_load_q : (lt_ctl_q.up ? 16'h0000 : 16'hffff);
  assign lt_cap_hit = lt_ctl_q.cap_en & ~lt_ctl_q.wide & src_rise[lt_ctl_q.evt];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_ctl_q <= `LTG_LT_CON_RST;
    else if (wr_lt_con) lt_ctl_q <= pwdata & `LTG_LT_CON_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_load_q <= `LTG_LT_LOAD_RST;
    else if (wr_lt_load) lt_load_q <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_pre_q <= 15'h0000;
    else if (wr_lt_con) lt_pre_q <= 15'h0000;
    else if (lt_ctl_q.en && lt_src) lt_pre_q <= lt_pre_q + 15'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_cnt_q <= `LTG_LT_CNT_RST;
    else if (wr_lt_con) begin
      if (pwdata[`LTG_WIDE_BIT]) lt_cnt_q <= 48'h000000000000;
      else if (pwdata[`LTG_PER_BIT]) lt_cnt_q <= {32'h00000000, lt_load_q};
      else lt_cnt_q <= pwdata[`LTG_UP_BIT] ? 48'h000000000000 : 48'h00000000ffff;
    end else if (wr_lt_clr && !lt_ctl_q.wide) lt_cnt_q <= {32'h00000000, lt_load_q};
    else if (lt_to) lt_cnt_q <= lt_ctl_q.wide ? 48'h000000000000 : {32'h00000000, lt_start};
    else if (lt_tick) begin
      if (lt_ctl_q.wide || lt_ctl_q.up) lt_cnt_q <= lt_cnt_q + 48'h000000000001;
      else lt_cnt_q <= {32'h00000000, lt_cnt_q[15:0] - 16'h0001};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_cap_q <= `LTG_LT_CAP_RST;
    else if (lt_cap_hit) lt_cap_q <= lt_cnt_q[15:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lt_irq_q <= 1'b0;
    else if (lt_to) lt_irq_q <= 1'b1;
    else if (wr_lt_clr) lt_irq_q <= 1'b0;
  end

  // General timer
  ltg_gt_ctl_type gt_ctl_q;
  logic [31:0]    gt_load_q;
  logic [31:0]    gt_cnt_q;
  logic [31:0]    gt_cap_q;
  logic [14:0]    gt_pre_q;
  logic [7:0]     gt_ps_q;
  logic [7:0]     gt_tgt_q;
  logic           gt_irq_q;
  logic           gt_src;
  logic           gt_tick;
  logic           gt_to;
  logic           gt_ps_on;
  logic           gt_ps_match;
  logic           gt_time;
  logic [7:0]     gt_hr;
  logic [31:0]    gt_full;
  logic [31:0]    gt_endv;
  logic [31:0]    gt_start;

  always_comb begin
    case (gt_ctl_q.clk)
      3'd0:    gt_src = ~low_power;
      3'd1:    gt_src = rise_lp;
      3'd2:    gt_src = rise_g8;
      3'd3:    gt_src = rise_g5;
      default: gt_src = 1'b0;
    endcase
  end

  assign gt_time = gt_ctl_q.fmt == fmt_day || gt_ctl_q.fmt == fmt_long;
  assign gt_hr = (gt_ctl_q.fmt == fmt_day) ? `LTG_HR_DAY : `LTG_HR_LONG;
  assign gt_full = gt_time ? tm_max(gt_hr) : 32'hffffffff;
  assign gt_endv = gt_ctl_q.up ? gt_full : 32'h00000000;
  assign gt_start = gt_ctl_q.per ? gt_load_q : (gt_ctl_q.up ? 32'h00000000 : gt_full);
  assign gt_tick = gt_ctl_q.en & gt_src & pre_hit(gt_pre_q, gt_ctl_q.pre);
  assign gt_to = gt_tick & (gt_cnt_q == gt_endv);
  assign gt_ps_on = gt_ctl_q.ps_en | gt_ctl_q.irq_sel;
  assign gt_ps_match = gt_ps_q + 8'd1 == gt_tgt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_ctl_q <= `LTG_GT_CON_RST;
    else if (wr_gt_con) gt_ctl_q <= pwdata & `LTG_GT_CON_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_tgt_q <= 8'h01;
    else if (wr_gt_con) begin
      gt_tgt_q <= (pwdata[31:24] == 8'h00) ? 8'h01 : pwdata[31:24];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_load_q <= `LTG_GT_LOAD_RST;
    else if (wr_gt_load) gt_load_q <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_pre_q <= 15'h0000;
    else if (wr_gt_con) gt_pre_q <= 15'h0000;
    else if (gt_ctl_q.en && gt_src) gt_pre_q <= gt_pre_q + 15'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_cnt_q <= `LTG_GT_CNT_RST;
    else if (wr_gt_con) gt_cnt_q <= gt_start_w(pwdata);
    else if (wr_gt_clr) gt_cnt_q <= gt_load_q;
    else if (gt_to) gt_cnt_q <= gt_start;
    else if (gt_tick) begin
      if (gt_time) gt_cnt_q <= tm_step(gt_cnt_q, gt_ctl_q.up, gt_hr);
      else gt_cnt_q <= gt_ctl_q.up ? gt_cnt_q + 32'h00000001 : gt_cnt_q - 32'h00000001;
    end
  end

  // Start value for a control word being written
  function automatic logic [31:0] gt_start_w(input logic [31:0] w);
    logic [31:0] full;
    full = (w[5:4] == 2'b10) ? tm_max(`LTG_HR_DAY) :
           (w[5:4] == 2'b11) ? tm_max(`LTG_HR_LONG) : 32'hffffffff;
    if (w[`LTG_PER_BIT]) return gt_load_q;
    return w[`LTG_UP_BIT] ? 32'h00000000 : full;
  endfunction

  logic gt_flag_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gt_ps_q   <= 8'h00;
      gt_flag_q <= 1'b0;
    end else if (gt_to && gt_ps_on) begin
      gt_ps_q <= gt_ps_match ? 8'h00 : gt_ps_q + 8'd1;
      if (gt_ps_match) gt_flag_q <= 1'b1;
    end else if (wr_gt_con || wr_gt_clr) begin
      gt_ps_q   <= 8'h00;
      gt_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_cap_q <= `LTG_GT_CAP_RST;
    else if (gt_ctl_q.cap_en && src_rise[gt_ctl_q.evt]) gt_cap_q <= gt_cnt_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gt_irq_q <= 1'b0;
    else if (gt_to && (!gt_ctl_q.irq_sel || gt_ps_match)) gt_irq_q <= 1'b1;
    else if (wr_gt_clr) gt_irq_q <= 1'b0;
  end

  // Read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (setup && !pwrite) begin
      case (paddr)
        `LTG_LT_LOAD_ADDR: prdata <= {16'h0000, lt_load_q};
        `LTG_LT_VAL0_ADDR: prdata <= {16'h0000, lt_cnt_q[15:0]};
        `LTG_LT_VAL1_ADDR: prdata <= lt_cnt_q[47:16];
        `LTG_LT_CON_ADDR:  prdata <= lt_ctl_q;
        `LTG_LT_CAP_ADDR:  prdata <= {16'h0000, lt_cap_q};
        `LTG_GT_LOAD_ADDR: prdata <= gt_load_q;
        `LTG_GT_VAL_ADDR:  prdata <= gt_cnt_q;
        `LTG_GT_CON_ADDR:  prdata <= {gt_ps_q, gt_ctl_q[23:20], gt_flag_q, gt_ctl_q[18:0]};
        `LTG_GT_CAP_ADDR:  prdata <= gt_cap_q;
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  assign lt_irq = lt_irq_q;
  assign gt_irq = gt_irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lt_start_down: assert property (wr_lt_con && !pwdata[4] && !pwdata[6] && !pwdata[8]
    |=> lt_cnt_q[15:0] == 16'hffff) else $error("lifetime start value wrong");
  chk_lt_free_wrap: assert property (lt_to && !lt_ctl_q.wide && !lt_ctl_q.per && !wr_lt_con
    && !wr_lt_clr |=> lt_cnt_q[15:0] == (lt_ctl_q.up ? 16'h0000 : 16'hffff))
    else $error("lifetime free-running wrap wrong");
  chk_lt_period_reload: assert property (lt_to && !lt_ctl_q.wide && lt_ctl_q.per
    && !wr_lt_con |=> lt_cnt_q[15:0] == $past(lt_load_q)) else $error("periodic reload wrong");
  chk_lt_irq_raise: assert property (lt_to |=> lt_irq_q) else $error("lifetime irq missing");
  chk_lt_clear_reload: assert property (wr_lt_clr && !lt_ctl_q.wide && !lt_to
    |=> !lt_irq_q && lt_cnt_q[15:0] == $past(lt_load_q)) else $error("lifetime clear wrong");
  chk_lt_wide_wrap: assert property (lt_to && lt_ctl_q.wide && !wr_lt_con
    |=> lt_cnt_q == 48'h000000000000) else $error("wide wrap wrong");
  chk_lt_capture: assert property (lt_cap_hit |=> lt_cap_q == $past(lt_cnt_q[15:0]))
    else $error("lifetime capture wrong");
  chk_lt_idle_hold: assert property (!lt_ctl_q.en && !wr_lt_con && !wr_lt_clr
    |=> $stable(lt_cnt_q)) else $error("disabled lifetime counter moved");
  chk_gt_direct_irq: assert property (gt_to && !gt_ctl_q.irq_sel |=> gt_irq_q)
    else $error("general direct irq missing");
  chk_gt_irq_hold: assert property (gt_irq_q && !wr_gt_clr |=> gt_irq_q)
    else $error("general irq dropped without clear");
  chk_gt_clear_reload: assert property (wr_gt_clr && !wr_gt_con ##1 1'b1
    |-> gt_cnt_q == $past(gt_load_q)) else $error("general clear reload wrong");
  chk_gt_ps_flag: assert property (gt_to && gt_ps_on && gt_ps_match |=> gt_flag_q)
    else $error("post-scaler flag missing");

  cov_lt_timeout: cover property (lt_to ##1 lt_irq_q);
  cov_lt_capture: cover property (lt_cap_hit);
  cov_gt_postscale: cover property (gt_to && gt_ctl_q.irq_sel && gt_ps_match);
  cov_gt_time_wrap: cover property (gt_to && gt_time);

endmodule
`default_nettype wire

// file: shared/ltg_cfg.svh
`ifndef LTG_CFG_SVH
`define LTG_CFG_SVH

// Register byte addresses
`define LTG_LT_LOAD_ADDR   32'hffff0300
`define LTG_LT_VAL0_ADDR   32'hffff0304
`define LTG_LT_VAL1_ADDR   32'hffff0308
`define LTG_LT_CON_ADDR    32'hffff030c
`define LTG_LT_CLR_ADDR    32'hffff0310
`define LTG_LT_CAP_ADDR    32'hffff0314
`define LTG_GT_LOAD_ADDR   32'hffff0320
`define LTG_GT_VAL_ADDR    32'hffff0324
`define LTG_GT_CON_ADDR    32'hffff0328
`define LTG_GT_CLR_ADDR    32'hffff032c
`define LTG_GT_CAP_ADDR    32'hffff0330

// Field positions of the control registers
`define LTG_PS_LSB         24
`define LTG_PS_EN_BIT      23
`define LTG_PS_FLAG_BIT    19
`define LTG_IRQ_SEL_BIT    18
`define LTG_CAP_EN_BIT     17
`define LTG_EVT_LSB        12
`define LTG_CLK_LSB        9
`define LTG_UP_BIT         8
`define LTG_EN_BIT         7
`define LTG_PER_BIT        6
`define LTG_FMT_LSB        4
`define LTG_WIDE_BIT       4
`define LTG_PRE_LSB        0

// Writable bits of the control registers
`define LTG_LT_CON_WMASK   32'h0003f7df
`define LTG_GT_CON_WMASK   32'hff87ffff

// Reset values
`define LTG_LT_LOAD_RST    16'h0000
`define LTG_LT_CNT_RST     48'h000000000000
`define LTG_LT_CON_RST     32'h00000000
`define LTG_LT_CAP_RST     16'h0000
`define LTG_GT_LOAD_RST    32'h00000000
`define LTG_GT_CNT_RST     32'h0fffffff
`define LTG_GT_CON_RST     32'h00000000
`define LTG_GT_CAP_RST     32'h00000000

// Time format limits
`define LTG_HR_DAY         8'd23
`define LTG_HR_LONG        8'd255
`define LTG_MIN_MAX        8'd59
`define LTG_SEC_MAX        8'd59
`define LTG_HUND_MAX       8'd99

`endif

// file: shared/ltg_pkg.sv
package ltg_pkg;

  typedef enum logic [1:0] {fmt_binary, fmt_reserved, fmt_day, fmt_long} ltg_fmt_type;

  // Clock source pins, asynchronous to pclk
  typedef struct packed {
    logic lp_osc;
    logic xtal;
    logic prec_osc;
    logic gpio8;
    logic gpio5;
  } ltg_pins_type;

  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic        cap_en;
    logic [4:0]  evt;
    logic        rsvd11;
    logic [1:0]  clk;
    logic        up;
    logic        en;
    logic        per;
    logic        rsvd5;
    logic        wide;
    logic [3:0]  pre;
  } ltg_lt_ctl_type;

  typedef struct packed {
    logic [7:0]  ps;
    logic        ps_en;
    logic [2:0]  rsvd;
    logic        ps_flag;
    logic        irq_sel;
    logic        cap_en;
    logic [4:0]  evt;
    logic [2:0]  clk;
    logic        up;
    logic        en;
    logic        per;
    ltg_fmt_type fmt;
    logic [3:0]  pre;
  } ltg_gt_ctl_type;

endpackage

// file: tb/ltg_timers_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ltg_cfg.svh"

module ltg_timers_test
  import ltg_pkg::*;
;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  ltg_pins_type src_pins;
  logic         low_power;
  logic [31:0]  irq_src;
  logic         lt_irq;
  logic         gt_irq;
  logic [4:0]   pin_mask;
  logic [1:0]   pin_cnt;
  logic [31:0]  rd;
  logic         slv_err;
  int           err_total;
  int           check_count;

  ltg_timers dut_u (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .src_pins  (src_pins),
    .low_power (low_power),
    .irq_src   (irq_src),
    .lt_irq    (lt_irq),
    .gt_irq    (gt_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Selected source pins toggle every 4 cycles
  always @(posedge pclk) begin
    if (!presetn) begin
      pin_cnt  <= 2'h0;
      src_pins <= '0;
    end else begin
      pin_cnt <= pin_cnt + 2'd1;
      if (pin_cnt == 2'd3) src_pins <= src_pins ^ pin_mask;
    end
  end

  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    rng(got, exp, exp);
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_irq(input logic g, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((g ? gt_irq : lt_irq) !== 1'b1 && n < 200);
    rng(n, lo, hi);
  endtask

  task automatic final_report;
    $display("TB: checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_reset;
    logic [31:0] ra [11] = '{`LTG_LT_LOAD_ADDR, `LTG_LT_VAL0_ADDR, `LTG_LT_VAL1_ADDR,
      `LTG_LT_CON_ADDR, `LTG_LT_CLR_ADDR, `LTG_LT_CAP_ADDR, `LTG_GT_LOAD_ADDR,
      `LTG_GT_CON_ADDR, `LTG_GT_CLR_ADDR, `LTG_GT_CAP_ADDR, `LTG_GT_VAL_ADDR};
    for (int i = 0; i < 11; i++) begin
      rdx(ra[i], i == 10 ? 32'h0fffffff : 32'h0);
      chk({31'h0, slv_err}, 32'h0);
    end
    chk({30'h0, lt_irq, gt_irq}, 32'h0);
    apb(1'b0, 32'hffff0318, 32'h0);
    chk({31'h0, slv_err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_start;
    logic [15:0] cv [10] = '{16'h0000, 16'h0100, 16'h0040, 16'h0140, 16'h0050,
      16'h0000, 16'h0020, 16'h0030, 16'h0100, 16'h0040};
    logic [31:0] ex [10] = '{32'h0000ffff, 32'h0, 32'h1234, 32'h1234, 32'h0,
      32'hffffffff, 32'h173b3b63, 32'hff3b3b63, 32'h0, 32'ha5a5a5a5};
    wr(`LTG_LT_LOAD_ADDR, 32'hffffffff);
    rdx(`LTG_LT_LOAD_ADDR, 32'h0000ffff);
    wr(`LTG_LT_LOAD_ADDR, 32'h1234);
    wr(`LTG_GT_LOAD_ADDR, 32'ha5a5a5a5);
    rdx(`LTG_GT_LOAD_ADDR, 32'ha5a5a5a5);
    wr(`LTG_LT_CON_ADDR, 32'hffffffff);
    rdx(`LTG_LT_CON_ADDR, `LTG_LT_CON_WMASK);
    for (int i = 0; i < 10; i++) begin
      wr(i < 5 ? `LTG_LT_CON_ADDR : `LTG_GT_CON_ADDR, {16'h0, cv[i]});
      rdx(i < 5 ? `LTG_LT_VAL0_ADDR : `LTG_GT_VAL_ADDR, ex[i]);
    end
    wr(`LTG_GT_VAL_ADDR, 32'h0);
    rdx(`LTG_GT_VAL_ADDR, 32'ha5a5a5a5);
  endtask

  // Count reached 602 cycles after a control write, per source and prescaler
  task automatic t_rate;
    logic [15:0] cv [16] = '{16'h0180, 16'h0184, 16'h0188, 16'h018f, 16'h0380, 16'h0580,
      16'h0780, 16'h0080, 16'h0090, 16'h0090, 16'h0180, 16'h0180, 16'h0380, 16'h0580,
      16'h0780, 16'h0184};
    logic [5:0]  mk [16] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h10, 6'h08, 6'h04, 6'h00,
      6'h00, 6'h00, 6'h00, 6'h20, 6'h30, 6'h22, 6'h21, 6'h00};
    logic [1:0]  sl [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 2, 2, 2, 2};
    int          lo [16] = '{599, 34, 0, 0, 70, 70, 70, 64930, 599, 0, 599, 0, 70, 70, 70, 34};
    int          sp [16] = '{6, 6, 4, 1, 10, 10, 10, 6, 6, 0, 6, 0, 10, 10, 10, 6};
    for (int i = 0; i < 16; i++) begin
      pin_mask  <= mk[i][4:0];
      low_power <= mk[i][5];
      wr(sl[i][1] ? `LTG_GT_CON_ADDR : `LTG_LT_CON_ADDR, {16'h0, cv[i]});
      repeat (600) @(posedge pclk);
      apb(1'b0, sl[i][1] ? `LTG_GT_VAL_ADDR :
        (sl[i][0] ? `LTG_LT_VAL1_ADDR : `LTG_LT_VAL0_ADDR), 32'h0);
      rng(rd, lo[i], lo[i] + sp[i]);
    end
    pin_mask  <= 5'h0;
    low_power <= 1'b0;
    // Time format: up from zero, and down from 255:59:59.99
    for (int i = 0; i < 2; i++) begin
      wr(`LTG_GT_CON_ADDR, i ? 32'h000000b0 : 32'h000001a0);
      repeat (600) @(posedge pclk);
      apb(1'b0, `LTG_GT_VAL_ADDR, 32'h0);
      rng(rd, i ? 32'hff3b3560 : 32'h00000600, i ? 32'hff3b3563 : 32'h00000603);
    end
  endtask

  task automatic t_irq;
    wr(`LTG_LT_LOAD_ADDR, 32'h5);
    wr(`LTG_LT_CON_ADDR, 32'hc0);
    wait_irq(1'b0, 5, 10);
    apb(1'b0, `LTG_LT_VAL0_ADDR, 32'h0);
    rng(rd, 0, 5);
    wr(`LTG_LT_CON_ADDR, 32'h40);
    wr(`LTG_LT_LOAD_ADDR, 32'h9);
    @(negedge pclk);
    chk({31'h0, lt_irq}, 32'h1);
    wr(`LTG_LT_CLR_ADDR, 32'h0);
    @(negedge pclk);
    chk({31'h0, lt_irq}, 32'h0);
    rdx(`LTG_LT_VAL0_ADDR, 32'h9);
    wr(`LTG_GT_LOAD_ADDR, 32'd20);
    wr(`LTG_GT_CON_ADDR, 32'h020400c0);
    wait_irq(1'b1, 38, 48);
    apb(1'b0, `LTG_GT_CON_ADDR, 32'h0);
    chk({31'h0, rd[`LTG_PS_FLAG_BIT]}, 32'h1);
    wr(`LTG_GT_CON_ADDR, 32'h40);
    wr(`LTG_GT_LOAD_ADDR, 32'h7);
    @(negedge pclk);
    chk({31'h0, gt_irq}, 32'h1);
    wr(`LTG_GT_CLR_ADDR, 32'h0);
    @(negedge pclk);
    chk({31'h0, gt_irq}, 32'h0);
    rdx(`LTG_GT_VAL_ADDR, 32'h7);
    wr(`LTG_GT_LOAD_ADDR, 32'd20);
    wr(`LTG_GT_CON_ADDR, 32'h000400c0);
    wait_irq(1'b1, 17, 26);
    wr(`LTG_GT_CON_ADDR, 32'h020000c0);
    wr(`LTG_GT_CLR_ADDR, 32'h0);
    wait_irq(1'b1, 14, 24);
    wr(`LTG_GT_CON_ADDR, 32'h0);
    wr(`LTG_GT_CLR_ADDR, 32'h0);
  endtask

  task automatic t_cap;
    logic [31:0] c;
    wr(`LTG_LT_CON_ADDR, 32'h00025180);
    wr(`LTG_GT_CON_ADDR, 32'h00027180);
    irq_src <= 32'h8;
    repeat (20) @(posedge pclk);
    rdx(`LTG_LT_CAP_ADDR, 32'h0);
    rdx(`LTG_GT_CAP_ADDR, 32'h0);
    irq_src <= 32'ha8;
    repeat (3) @(posedge pclk);
    for (int g = 0; g < 2; g++) begin
      apb(1'b0, g ? `LTG_GT_CAP_ADDR : `LTG_LT_CAP_ADDR, 32'h0);
      c = rd;
      rng(c, 20, 200);
      apb(1'b0, g ? `LTG_GT_VAL_ADDR : `LTG_LT_VAL0_ADDR, 32'h0);
      rng(rd, c + 1, c + 500);
      rdx(g ? `LTG_GT_CAP_ADDR : `LTG_LT_CAP_ADDR, c);
    end
    irq_src <= 32'h0;
  endtask

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h0;
    pwdata      = 32'h0;
    low_power   = 1'b0;
    irq_src     = 32'h0;
    pin_mask    = 5'h0;
    err_total   = 0;
    check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_rate();
    t_irq();
    t_cap();
    final_report();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule

`default_nettype wire
